//--- bench/uart_flow_and_bus_direction_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module uart_flow_and_bus_direction_tb_top;
    localparam int BITC = 8;
    logic       clk, sys_rst, half_duplex_mode, flow_ctrl_mode;
    logic       rx_pin, tx_pin, cts_pin, rts_pin;
    logic       receiver_buffer_off, line_driver_on;
    logic [7:0] tx_data, rx_data;
    logic       tx_valid, tx_ready, rx_valid, rx_ready;
    int         miscompares, n_tests, rts_seen;
    ufbd_uart #(.BIT_CYCLES(BITC)) i_dut (
        .clk, .sys_rst, .half_duplex_mode, .flow_ctrl_mode, .rx_pin, .tx_pin,
        .cts_pin, .rts_pin, .receiver_buffer_off, .line_driver_on, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready
    );
    ufbd_host_model #(.BITC(BITC)) i_host (.clk, .tx_pin, .rts_pin, .rx_pin);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (rts_pin === 1'b1) rts_seen++;
    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic put(input logic [7:0] b);
        tx_data  <= b;
        tx_valid <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 4000 && tx_ready !== 1'b1; i++) @(negedge clk);
        chk("tx_ready", tx_ready, 8'h01);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    task automatic pop(input logic [7:0] exp);
        @(negedge clk);
        for (int i = 0; i < 4000 && rx_valid !== 1'b1; i++) @(negedge clk);
        chk("rx_valid", rx_valid, 8'h01);
        chk("rx_byte", rx_data, exp);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask
    task automatic wait_host(input int n);
        for (int i = 0; i < 4000 && i_host.got_q.size() < n; i++) cyc(1);
        chk("host_bytes", 8'(i_host.got_q.size() >= n), 8'h01);
    endtask
    task automatic t_half;
        half_duplex_mode <= 1'b1;
        cyc(4);
        chk("dir_idle", line_driver_on, 8'h00);
        put(8'hA5);
        cyc(20);
        chk("dir_tx", {receiver_buffer_off, line_driver_on}, 8'h03);
        wait_host(1);
        cyc(12);
        chk("dir_done", {receiver_buffer_off, line_driver_on}, 8'h00);
        chk("tx_a5", i_host.got_q[0], 8'hA5);
    endtask
    task automatic t_duplex;
        fork
            i_host.send_byte(8'h5A);
            put(8'hC3);
        join
        wait_host(2);
        chk("tx_c3", i_host.got_q[1], 8'hC3);
        pop(8'h5A);
    endtask
    task automatic t_cts_hold;
        half_duplex_mode <= 1'b0;
        flow_ctrl_mode   <= 1'b1;
        cts_pin          <= 1'b1;
        cyc(4);
        fork
            put(8'h96);
            begin
                cyc(60);
                chk("held", 8'(i_host.got_q.size()), 8'h02);
                chk("tx_idle", tx_pin, 8'h01);
                cts_pin <= 1'b0;
            end
        join
        wait_host(3);
        chk("tx_96", i_host.got_q[2], 8'h96);
    endtask
    task automatic t_cts_mid;
        put(8'h0F);
        cyc(30);
        cts_pin <= 1'b1;
        fork
            put(8'hF0);
            begin
                wait_host(4);
                cyc(150);
                chk("once", 8'(i_host.got_q.size()), 8'h04);
                chk("tx_0f", i_host.got_q[3], 8'h0F);
                cts_pin <= 1'b0;
            end
        join
        wait_host(5);
        chk("tx_f0", i_host.got_q[4], 8'hF0);
        chk("count", 8'(i_host.got_q.size()), 8'h05);
    endtask
    task automatic t_rx_rts;
        chk("rts_idle", rts_pin, 8'h00);
        rts_seen = 0;
        i_host.send_byte(8'h81);
        i_host.send_byte(8'h7E);
        pop(8'h81);
        pop(8'h7E);
        chk("rts_pulse", 8'(rts_seen), 8'h02);
        chk("rts_low", rts_pin, 8'h00);
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 32; i++) i_host.send_byte(8'(i * 7));
        cyc(20);
        chk("full_rts", rts_pin, 8'h01);
        for (int i = 0; i < 32; i++) pop(8'(i * 7));
        cyc(4);
        chk("empty", rx_valid, 8'h00);
        chk("free_rts", rts_pin, 8'h00);
    endtask
    initial begin
        sys_rst          = 1'b1;
        half_duplex_mode = 1'b0;
        flow_ctrl_mode   = 1'b0;
        cts_pin          = 1'b0;
        tx_data          = 8'h00;
        tx_valid         = 1'b0;
        rx_ready         = 1'b0;
        miscompares      = 0;
        n_tests          = 0;
        rts_seen         = 0;
        cyc(12);
        sys_rst <= 1'b0;
        cyc(4);
        chk("rst_tx", tx_pin, 8'h01);
        chk("rst_rxv", rx_valid, 8'h00);
        t_half;
        t_duplex;
        t_cts_hold;
        t_cts_mid;
        t_rx_rts;
        t_fifo;
        chk("stop_bits", i_host.frame_err, 8'h00);
        test_done;
    end
    initial begin
        cyc(20000);
        miscompares++;
        test_done;
    end
endmodule // uart_flow_and_bus_direction_tb_top
`default_nettype wire

//--- bench/ufbd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufbd_host_model #(
    parameter int BITC = 8
) (
    input  wire logic clk,
    input  wire logic tx_pin,
    input  wire logic rts_pin,
    output logic      rx_pin
);
    logic [7:0] got_q[$];
    logic       frame_err;
    initial rx_pin = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (rts_pin === 1'b1) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (BITC) @(posedge clk);
        end
    endtask
    // --------------------------------
    // Mid-bit sampling of device output
    // --------------------------------
    initial begin
        logic [7:0] b;
        frame_err = 1'b0;
        forever begin
            @(negedge tx_pin);
            repeat (BITC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BITC) @(posedge clk);
                b[i] = tx_pin;
            end
            repeat (BITC) @(posedge clk);
            if (tx_pin !== 1'b1) frame_err = 1'b1;
            got_q.push_back(b);
        end
    end
endmodule // ufbd_host_model
`default_nettype wire

//--- bench/ufbd_uart_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ufbd_uart_sva #(
    parameter int unsigned BIT_CYCLES = 8
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       half_duplex_mode,
    input wire logic       flow_ctrl_mode,
    input wire logic       rx_pin,
    input wire logic       tx_pin,
    input wire logic       cts_pin,
    input wire logic       rts_pin,
    input wire logic       receiver_buffer_off,
    input wire logic       line_driver_on,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready
);
    localparam int STOP_M = 9 * BIT_CYCLES;
    localparam int FRAME  = 10 * BIT_CYCLES;
    int gap_q;
    always_ff @(posedge clk) begin
        if (sys_rst)
            gap_q <= FRAME;
        else if (tx_valid && tx_ready)
            gap_q <= 1;
        else if (gap_q < FRAME)
            gap_q <= gap_q + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_dirs_same: assert property (
        receiver_buffer_off == line_driver_on)
        else $error("direction outputs differ");
    a_dirs_idle: assert property (
        !half_duplex_mode && !$past(half_duplex_mode) |-> !line_driver_on)
        else $error("direction outputs high outside half duplex");
    a_dirs_tx: assert property (
        tx_valid && tx_ready && half_duplex_mode |=> line_driver_on [*8])
        else $error("direction outputs low while sending");
    a_frame_bits: assert property (
        tx_valid && tx_ready |-> ##1 !tx_pin ##STOP_M tx_pin)
        else $error("start or stop level wrong");
    a_tx_gap: assert property (
        tx_ready |-> gap_q >= FRAME)
        else $error("byte taken before frame ended");
    a_cts_block: assert property (
        flow_ctrl_mode && $past(cts_pin) && $past(cts_pin, 2) |-> !tx_ready)
        else $error("byte taken while clear-to-send high");
    a_rts_noflow: assert property (
        !flow_ctrl_mode && !$past(flow_ctrl_mode) && !$past(sys_rst)
        |-> !rts_pin)
        else $error("request-to-send high without flow control");
    a_rts_push: assert property (
        flow_ctrl_mode && $rose(rx_valid) |-> rts_pin || $past(rts_pin))
        else $error("no busy pulse on receive");
endmodule // ufbd_uart_sva
bind ufbd_uart ufbd_uart_sva #(.BIT_CYCLES(BIT_CYCLES)) i_sva (
    .clk, .sys_rst, .half_duplex_mode, .flow_ctrl_mode, .rx_pin, .tx_pin,
    .cts_pin, .rts_pin, .receiver_buffer_off, .line_driver_on, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready
);
`default_nettype wire

//--- core/ufbd_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ufbd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    ufbd_stream_if.snk wr,
    ufbd_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    wp_d;
    logic [AW-1:0]    rp_q;
    logic [AW-1:0]    rp_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem[rp_q];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end
endmodule // ufbd_fifo
`default_nettype wire

//--- core/ufbd_pkg.sv
package ufbd_pkg;
    // ------------------------------------------------------------
    // Timing and frame
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 250_000_000;
    localparam int unsigned BAUD_DEFAULT = 115_200;
    localparam int unsigned DATA_BITS    = 8;
    localparam int unsigned STOP_BITS    = 1;
    localparam int unsigned FIFO_DEPTH   = 32;
    localparam int unsigned BIT_CYCLES   = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
    localparam int unsigned CNT_W        = 16;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic        LINE_IDLE    = 1'b1;
    localparam logic        START_LVL    = 1'b0;
    localparam logic        STOP_LVL     = 1'b1;

    typedef enum logic [1:0] {
        UFBD_IDLE  = 2'b00,
        UFBD_START = 2'b01,
        UFBD_DATA  = 2'b10,
        UFBD_STOP  = 2'b11
    } ufbd_state_type;
endpackage

//--- core/ufbd_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ufbd_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- core/ufbd_uart.sv
`timescale 1ns/10ps
`default_nettype none
module ufbd_uart #(
    parameter int unsigned BIT_CYCLES = ufbd_pkg::BIT_CYCLES,
    parameter int unsigned DEPTH      = ufbd_pkg::FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       half_duplex_mode,
    input  wire logic       flow_ctrl_mode,
    input  wire logic       rx_pin,
    output logic            tx_pin,
    input  wire logic       cts_pin,
    output logic            rts_pin,
    output logic            receiver_buffer_off,
    output logic            line_driver_on,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    localparam logic [ufbd_pkg::CNT_W-1:0] BIT_LAST =
        ufbd_pkg::CNT_W'(BIT_CYCLES - 1);
    localparam logic [ufbd_pkg::CNT_W-1:0] HALF_LAST =
        ufbd_pkg::CNT_W'(BIT_CYCLES / 2 - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rx_sync_q;
    logic [1:0] cts_sync_q;
    logic       rx_s;
    logic       cts_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_sync_q  <= {2{ufbd_pkg::LINE_IDLE}};
            cts_sync_q <= 2'h3;
        end else begin
            rx_sync_q  <= {rx_sync_q[0], rx_pin};
            cts_sync_q <= {cts_sync_q[0], cts_pin};
        end
    end
    assign rx_s  = rx_sync_q[1];
    assign cts_s = cts_sync_q[1];

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    ufbd_pkg::ufbd_state_type  tx_st_q, tx_st_d;
    logic [ufbd_pkg::CNT_W-1:0] tx_cnt_q, tx_cnt_d;
    logic [2:0]                 tx_bit_q, tx_bit_d;
    logic [7:0]                 tx_sh_q, tx_sh_d;
    logic                       tx_q, tx_d;
    logic                       tx_go;

    // Byte start gated by clear-to-send only at the byte boundary
    assign tx_go    = tx_valid && (!flow_ctrl_mode || !cts_s);
    assign tx_ready = (tx_st_q == ufbd_pkg::UFBD_IDLE) && tx_go;

    always_comb begin
        tx_st_d  = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d  = tx_sh_q;
        tx_d     = tx_q;
        case (tx_st_q)
            ufbd_pkg::UFBD_IDLE: begin
                tx_d = ufbd_pkg::LINE_IDLE;
                if (tx_go) begin
                    tx_sh_d  = tx_data;
                    tx_cnt_d = '0;
                    tx_d     = ufbd_pkg::START_LVL;
                    tx_st_d  = ufbd_pkg::UFBD_START;
                end
            end
            ufbd_pkg::UFBD_START, ufbd_pkg::UFBD_DATA: begin
                // Mid-byte clear-to-send is ignored
                if (tx_cnt_q == BIT_LAST) begin
                    tx_cnt_d = '0;
                    if (tx_st_q == ufbd_pkg::UFBD_START) begin
                        tx_bit_d = '0;
                        tx_d     = tx_sh_q[0];
                        tx_st_d  = ufbd_pkg::UFBD_DATA;
                    end else if (tx_bit_q == ufbd_pkg::LAST_BIT) begin
                        tx_d    = ufbd_pkg::STOP_LVL;
                        tx_st_d = ufbd_pkg::UFBD_STOP;
                    end else begin
                        tx_bit_d = 3'(tx_bit_q + 1'b1);
                        tx_sh_d  = {1'b0, tx_sh_q[7:1]};
                        tx_d     = tx_sh_q[1];
                    end
                end else begin
                    tx_cnt_d = ufbd_pkg::CNT_W'(tx_cnt_q + 1'b1);
                end
            end
            ufbd_pkg::UFBD_STOP: begin
                if (tx_cnt_q == BIT_LAST) begin
                    tx_cnt_d = '0;
                    tx_st_d  = ufbd_pkg::UFBD_IDLE;
                end else begin
                    tx_cnt_d = ufbd_pkg::CNT_W'(tx_cnt_q + 1'b1);
                end
            end
            default: begin
                tx_st_d = ufbd_pkg::UFBD_IDLE;
                tx_d    = ufbd_pkg::LINE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_st_q  <= ufbd_pkg::UFBD_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q  <= '0;
            tx_q     <= ufbd_pkg::LINE_IDLE;
        end else begin
            tx_st_q  <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q  <= tx_sh_d;
            tx_q     <= tx_d;
        end
    end
    assign tx_pin = tx_q;

    // ------------------------------------------------------------
    // Direction control
    // ------------------------------------------------------------
    logic dir_q, dir_d;

    always_comb begin
        dir_d = half_duplex_mode && (tx_st_d != ufbd_pkg::UFBD_IDLE);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_q <= 1'b0;
        end else begin
            dir_q <= dir_d;
        end
    end
    assign receiver_buffer_off = dir_q;
    assign line_driver_on      = dir_q;

    // ------------------------------------------------------------
    // Receiver, runs in every mode
    // ------------------------------------------------------------
    ufbd_pkg::ufbd_state_type  rx_st_q, rx_st_d;
    logic [ufbd_pkg::CNT_W-1:0] rx_cnt_q, rx_cnt_d;
    logic [2:0]                 rx_bit_q, rx_bit_d;
    logic [7:0]                 rx_sh_q, rx_sh_d;
    logic                       mv_q, mv_d;
    logic [7:0]                 mv_byte_q, mv_byte_d;

    ufbd_stream_if #(.WIDTH(8)) wr_if ();
    ufbd_stream_if #(.WIDTH(8)) rd_if ();

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_cnt_d  = rx_cnt_q;
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        mv_d      = mv_q;
        mv_byte_d = mv_byte_q;
        if (mv_q && wr_if.ready) begin
            mv_d = 1'b0;
        end
        case (rx_st_q)
            ufbd_pkg::UFBD_IDLE: begin
                rx_cnt_d = '0;
                if (rx_s == ufbd_pkg::START_LVL) begin
                    rx_st_d = ufbd_pkg::UFBD_START;
                end
            end
            ufbd_pkg::UFBD_START: begin
                if (rx_cnt_q == HALF_LAST) begin
                    rx_cnt_d = '0;
                    rx_bit_d = '0;
                    rx_st_d  = (rx_s == ufbd_pkg::START_LVL) ?
                               ufbd_pkg::UFBD_DATA : ufbd_pkg::UFBD_IDLE;
                end else begin
                    rx_cnt_d = ufbd_pkg::CNT_W'(rx_cnt_q + 1'b1);
                end
            end
            ufbd_pkg::UFBD_DATA: begin
                if (rx_cnt_q == BIT_LAST) begin
                    rx_cnt_d = '0;
                    rx_sh_d  = {rx_s, rx_sh_q[7:1]};
                    if (rx_bit_q == ufbd_pkg::LAST_BIT) begin
                        rx_st_d = ufbd_pkg::UFBD_STOP;
                    end else begin
                        rx_bit_d = 3'(rx_bit_q + 1'b1);
                    end
                end else begin
                    rx_cnt_d = ufbd_pkg::CNT_W'(rx_cnt_q + 1'b1);
                end
            end
            ufbd_pkg::UFBD_STOP: begin
                if (rx_cnt_q == BIT_LAST) begin
                    rx_st_d = ufbd_pkg::UFBD_IDLE;
                    // Framing error drops the byte
                    if (rx_s == ufbd_pkg::STOP_LVL) begin
                        mv_d      = 1'b1;
                        mv_byte_d = rx_sh_q;
                    end
                end else begin
                    rx_cnt_d = ufbd_pkg::CNT_W'(rx_cnt_q + 1'b1);
                end
            end
            default: begin
                rx_st_d = ufbd_pkg::UFBD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_st_q   <= ufbd_pkg::UFBD_IDLE;
            rx_cnt_q  <= '0;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            mv_q      <= 1'b0;
            mv_byte_q <= '0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_cnt_q  <= rx_cnt_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            mv_q      <= mv_d;
            mv_byte_q <= mv_byte_d;
        end
    end

    // ------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------
    assign wr_if.valid = mv_q;
    assign wr_if.data  = mv_byte_q;
    assign rd_if.ready = rx_ready;
    assign rx_valid    = rd_if.valid;
    assign rx_data     = rd_if.data;

    ufbd_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr      (wr_if),
        .rd      (rd_if)
    );

    // Busy while a byte is being moved in or the FIFO is full
    logic rts_q, rts_d;
    always_comb begin
        rts_d = flow_ctrl_mode && (mv_d || !wr_if.ready);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rts_q <= 1'b1;
        end else begin
            rts_q <= rts_d;
        end
    end
    assign rts_pin = rts_q;
endmodule // ufbd_uart
`default_nettype wire
